// >>> hw/nv_ctrl_pkg.sv
package nv_ctrl_pkg;

    // Sequence addresses, in order; the sixth selects store or recall
    localparam logic [12:0] SEQ_ADDR_0   = 13'h0000;
    localparam logic [12:0] SEQ_ADDR_1   = 13'h1555;
    localparam logic [12:0] SEQ_ADDR_2   = 13'h0AAA;
    localparam logic [12:0] SEQ_ADDR_3   = 13'h1FFF;
    localparam logic [12:0] SEQ_ADDR_4   = 13'h10F0;
    localparam logic [12:0] SEQ_STORE    = 13'h0F0F;
    localparam logic [12:0] SEQ_RECALL   = 13'h0F0E;
    localparam int          SEQ_STEPS    = 6;

    // Clock rate
    localparam int          CLK_MHZ      = 200;

    // Times in their own units
    localparam int          STORE_MS     = 10;     // store_duration
    localparam int          RECALL_US    = 20;     // recall_duration bound
    localparam int          PULSE_NS     = 60;     // strobe low time per bus cycle
    localparam int          GAP_NS       = 30;     // strobe high time between cycles
    localparam int          ENTRY_US     = 20;     // store_entry_delay bound

    // Cycle counts derived from times (least times round up)
    localparam int          STORE_CYC    = STORE_MS * 1000 * CLK_MHZ;
    localparam int          RECALL_CYC   = RECALL_US * CLK_MHZ;
    localparam int          ENTRY_CYC    = ENTRY_US * CLK_MHZ;
    localparam int          PULSE_CYC    = (PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int          GAP_CYC      = (GAP_NS * CLK_MHZ + 999) / 1000;

    // Operation codes of the user port
    localparam logic [1:0]  OP_READ      = 2'h0;
    localparam logic [1:0]  OP_WRITE     = 2'h1;
    localparam logic [1:0]  OP_SW_STORE  = 2'h2;
    localparam logic [1:0]  OP_SW_RECALL = 2'h3;

endpackage : nv_ctrl_pkg

// >>> hw/nv_bus_cycle.sv
`timescale 1ns/1ps
// One chip-select-controlled SRAM bus cycle: strobe low, then a gap
module nv_bus_cycle #(
    parameter int PULSE = nv_ctrl_pkg::PULSE_CYC,
    parameter int GAP   = nv_ctrl_pkg::GAP_CYC
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // Cycle request
    input  wire logic        start,
    input  wire logic        is_write,
    output logic             busy,
    output logic             done,
    // Strobes to the memory
    output logic             chip_sel_n,
    output logic             wr_strobe_n,
    output logic             out_drive_n,
    output logic             data_oe
);

    localparam int CW = $clog2(PULSE + GAP + 1);

    initial
    begin
        if (PULSE < 1 || GAP < 1)
            $error("nv_bus_cycle: pulse and gap must be at least one cycle");
    end

    logic [CW-1:0] cnt_reg;          // Cycles left in the bus cycle
    logic          wr_reg;           // Current cycle is a write
    logic          low_phase;        // Strobes asserted

    assign busy      = (cnt_reg != '0);
    assign low_phase = (cnt_reg > CW'(GAP));
    assign done      = (cnt_reg == CW'(1));

    // Counter and strobe flops
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_reg     <= '0;
            wr_reg      <= 1'b0;
            chip_sel_n  <= 1'b1;
            wr_strobe_n <= 1'b1;
            out_drive_n <= 1'b1;
            data_oe     <= 1'b0;
        end
        else
        begin
            if (start && !busy)
            begin
                cnt_reg <= CW'(PULSE + GAP);
                wr_reg  <= is_write;
            end
            else if (busy)
            begin
                cnt_reg <= cnt_reg - CW'(1);
            end
            // Strobes match the phase in the same cycle, from flops set one cycle ahead
            chip_sel_n  <= !((start && !busy) || (busy && low_phase && cnt_reg != CW'(GAP + 1)));
            wr_strobe_n <= !(((start && !busy) ? is_write : wr_reg)
                             && ((start && !busy) || (low_phase && cnt_reg != CW'(GAP + 1))));
            out_drive_n <= !(((start && !busy) ? !is_write : !wr_reg)
                             && ((start && !busy) || (low_phase && cnt_reg != CW'(GAP + 1))));
            data_oe     <= ((start && !busy) ? is_write : wr_reg)
                           && ((start && !busy) || (low_phase && cnt_reg != CW'(GAP + 1)));
        end
    end

endmodule : nv_bus_cycle

// >>> hw/nv_store_recall_control.sv
`timescale 1ns/1ps
module nv_store_recall_control #(
    parameter int STORE_WAIT  = nv_ctrl_pkg::STORE_CYC,
    parameter int RECALL_WAIT = nv_ctrl_pkg::RECALL_CYC,
    parameter int ENTRY_WAIT  = nv_ctrl_pkg::ENTRY_CYC
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // User request port
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic [1:0]  req_op,
    input  wire logic [12:0] req_addr,
    input  wire logic [7:0]  req_wdata,
    input  wire logic        hw_store_req,
    // User answer port
    output logic             rsp_valid,
    output logic [7:0]       rsp_rdata,
    // Memory address and data pins
    output logic [12:0]      mem_addr,
    input  wire logic [7:0]  mem_data_i,
    output logic [7:0]       mem_data_o,
    output logic             mem_data_oe,
    // Memory strobes
    output logic             chip_sel_n,
    output logic             wr_strobe_n,
    output logic             out_drive_n,
    // Store-busy open-drain line
    input  wire logic        store_busy_line_n_i,
    output logic             store_busy_line_n_o,
    output logic             store_busy_line_n_oe
);

    localparam int WW = $clog2(STORE_WAIT + RECALL_WAIT + ENTRY_WAIT + 2);

    initial
    begin
        if (STORE_WAIT < 1 || RECALL_WAIT < 1 || ENTRY_WAIT < 1)
            $error("nv_store_recall_control: waits must be at least one cycle");
    end

    typedef enum logic [2:0] {
        ST_BOOT    = 3'b000,   // Waiting out power-up recall
        ST_IDLE    = 3'b001,   // Ready for requests
        ST_ACCESS  = 3'b010,   // One bus cycle in flight
        ST_SEQ     = 3'b011,   // Issuing the six sequence reads
        ST_HOLD    = 3'b100,   // Waiting out a store or recall
        ST_HW_WAIT = 3'b101,   // Line held low through entry delay and store time
        ST_RELEASE = 3'b110    // Line released, waiting for it to rise
    } state_t;

    state_t          state_reg, state_next;
    logic [WW-1:0]   wait_reg,  wait_next;    // Hold-off counter
    logic [2:0]      step_reg,  step_next;    // Sequence step
    logic            recall_reg, recall_next; // Sequence ends in recall
    logic            drive_reg, drive_next;   // Host pulls busy line low
    logic [12:0]     addr_reg,  addr_next;
    logic [7:0]      wdata_reg, wdata_next;
    logic            cyc_write_reg, cyc_write_next;
    logic            user_rd_reg, user_rd_next;
    logic            cyc_start;
    logic            cyc_busy;
    logic            cyc_done;

    // Expected address for a sequence step
    function automatic logic [12:0] seq_addr(input logic [2:0] s, input logic rcl);
        unique case (s)
            3'd0:    seq_addr = nv_ctrl_pkg::SEQ_ADDR_0;
            3'd1:    seq_addr = nv_ctrl_pkg::SEQ_ADDR_1;
            3'd2:    seq_addr = nv_ctrl_pkg::SEQ_ADDR_2;
            3'd3:    seq_addr = nv_ctrl_pkg::SEQ_ADDR_3;
            3'd4:    seq_addr = nv_ctrl_pkg::SEQ_ADDR_4;
            default: seq_addr = rcl ? nv_ctrl_pkg::SEQ_RECALL : nv_ctrl_pkg::SEQ_STORE;
        endcase
    endfunction : seq_addr

    // Line level as seen on the wire
    wire line_low   = !store_busy_line_n_i;
    wire take_req   = req_valid && req_ready;
    wire seq_last   = (step_reg == 3'(nv_ctrl_pkg::SEQ_STEPS - 1));

    // Accept only in idle with the line high
    assign req_ready            = (state_reg == ST_IDLE) && !line_low && !hw_store_req;
    assign store_busy_line_n_o  = 1'b0;
    assign store_busy_line_n_oe = drive_reg;
    assign mem_addr             = addr_reg;
    assign mem_data_o           = wdata_reg;

    nv_bus_cycle u_cycle (
        .clk_sys     (clk_sys),
        .rst_b       (rst_b),
        .start       (cyc_start),
        .is_write    (cyc_write_reg),
        .busy        (cyc_busy),
        .done        (cyc_done),
        .chip_sel_n  (chip_sel_n),
        .wr_strobe_n (wr_strobe_n),
        .out_drive_n (out_drive_n),
        .data_oe     (mem_data_oe)
    );

    // Next-state logic
    always_comb
    begin
        state_next     = state_reg;
        wait_next      = wait_reg;
        step_next      = step_reg;
        recall_next    = recall_reg;
        drive_next     = drive_reg;
        addr_next      = addr_reg;
        wdata_next     = wdata_reg;
        cyc_write_next = cyc_write_reg;
        user_rd_next   = user_rd_reg;
        cyc_start      = 1'b0;
        unique case (state_reg)
            ST_BOOT:
            begin
                // Power-up recall hold-off
                if (wait_reg == '0)
                    state_next = ST_IDLE;
                else
                    wait_next = wait_reg - WW'(1);
            end
            ST_IDLE:
            begin
                if (hw_store_req && !line_low)
                begin
                    // Pull the line, then leave entry delay plus store time
                    drive_next = 1'b1;
                    wait_next  = WW'(ENTRY_WAIT + STORE_WAIT);
                    state_next = ST_HW_WAIT;
                end
                else if (take_req && req_op[1])
                begin
                    // Sequence: reads only, strobes from step 0
                    step_next      = '0;
                    recall_next    = (req_op == nv_ctrl_pkg::OP_SW_RECALL);
                    addr_next      = nv_ctrl_pkg::SEQ_ADDR_0;
                    cyc_write_next = 1'b0;
                    user_rd_next   = 1'b0;
                    state_next     = ST_SEQ;
                end
                else if (take_req)
                begin
                    addr_next      = req_addr;
                    wdata_next     = req_wdata;
                    cyc_write_next = (req_op == nv_ctrl_pkg::OP_WRITE);
                    user_rd_next   = (req_op == nv_ctrl_pkg::OP_READ);
                    state_next     = ST_ACCESS;
                end
            end
            ST_ACCESS:
            begin
                cyc_start = !cyc_busy && !cyc_done;
                if (cyc_done)
                    state_next = ST_IDLE;
            end
            ST_SEQ:
            begin
                // Back-to-back reads, nothing between them
                cyc_start = !cyc_busy && !cyc_done;
                if (cyc_done)
                begin
                    if (seq_last)
                    begin
                        // Store or recall hold-off
                        wait_next  = recall_reg ? WW'(RECALL_WAIT) : WW'(STORE_WAIT);
                        state_next = ST_HOLD;
                    end
                    else
                    begin
                        step_next = step_reg + 3'd1;
                        addr_next = seq_addr(step_reg + 3'd1, recall_reg);
                    end
                end
            end
            ST_HOLD:
            begin
                // No strobes until the device is ready again
                if (wait_reg == '0 && !line_low)
                    state_next = ST_IDLE;
                else if (wait_reg != '0)
                    wait_next = wait_reg - WW'(1);
            end
            ST_HW_WAIT:
            begin
                // Keep line low through entry delay and store
                if (wait_reg == '0)
                begin
                    drive_next = 1'b0;
                    state_next = ST_RELEASE;
                end
                else
                    wait_next = wait_reg - WW'(1);
            end
            ST_RELEASE:
            begin
                // Device may still be busy; wait for the line high
                if (!line_low)
                    state_next = ST_IDLE;
            end
            default:
                state_next = ST_IDLE;
        endcase
    end

    // State flops
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg     <= ST_BOOT;
            wait_reg      <= WW'(RECALL_WAIT);
            step_reg      <= '0;
            recall_reg    <= 1'b0;
            drive_reg     <= 1'b0;
            addr_reg      <= 13'h0000;
            wdata_reg     <= 8'h00;
            cyc_write_reg <= 1'b0;
            user_rd_reg   <= 1'b0;
        end
        else
        begin
            state_reg     <= state_next;
            wait_reg      <= wait_next;
            step_reg      <= step_next;
            recall_reg    <= recall_next;
            drive_reg     <= drive_next;
            addr_reg      <= addr_next;
            wdata_reg     <= wdata_next;
            cyc_write_reg <= cyc_write_next;
            user_rd_reg   <= user_rd_next;
        end
    end

    // Read answer: data captured at end of the read strobe
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rsp_valid <= 1'b0;
            rsp_rdata <= 8'h00;
        end
        else
        begin
            rsp_valid <= (state_reg == ST_ACCESS) && cyc_done;
            // Sample while select and output drive still stand low; once
            // the strobes rise the memory no longer drives the data pins
            if ((state_reg == ST_ACCESS) && user_rd_reg && !chip_sel_n && !out_drive_n)
                rsp_rdata <= mem_data_i;
        end
    end

endmodule : nv_store_recall_control

// >>> verification/nv_device_model.sv
`timescale 1ns/1ps
// Behavioural memory with shadow array, timed store and recall, read-sequence detector
module nv_device_model #(
    parameter int STORE_T  = 20,
    parameter int RECALL_T = 20,
    parameter int ENTRY_T  = 20
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // Memory pins
    input  wire logic [12:0] mem_addr,
    input  wire logic [7:0]  mem_data_o,
    output logic [7:0]       mem_data_i,
    input  wire logic        chip_sel_n,
    input  wire logic        wr_strobe_n,
    input  wire logic        out_drive_n,
    // Store-busy line
    input  wire logic        line_n,
    output logic             pull_low
);
    logic [7:0]  sram [0:8191]; // Working array
    logic [7:0]  nv [0:8191];   // Shadow array
    logic [7:0]  last_q;        // Last data shown
    logic        cs_q;          // Select one cycle back
    logic        wr_seen;       // Write strobe seen in this cycle
    logic        wr_hold;       // Write standing when busy ended
    logic        written;       // Write since last store or recall
    logic        hw_seen;       // Line request already served
    logic [2:0]  step;          // Sequence step
    logic [12:0] step_addr;     // Address wanted at this step
    int          busy_cnt;      // Disabled cycles left
    int          entry_cnt;     // Cycles the line has been low
    int          n_stores = 0;
    int          n_recalls = 0;
    assign step_addr = (step == 3'd0) ? nv_ctrl_pkg::SEQ_ADDR_0 : (step == 3'd1) ?
        nv_ctrl_pkg::SEQ_ADDR_1 : (step == 3'd2) ? nv_ctrl_pkg::SEQ_ADDR_2 :
        (step == 3'd3) ? nv_ctrl_pkg::SEQ_ADDR_3 : nv_ctrl_pkg::SEQ_ADDR_4;
    // Unselected or disabled: a changing pattern, never the last value
    assign mem_data_i = (!chip_sel_n && !out_drive_n && busy_cnt == 0) ? sram[mem_addr] : ~last_q;
    // Copy to shadow, pull the line, go disabled; only sequence or line start it
    task automatic store_now();
        for (int i = 0; i < 8192; i++) nv[i] <= sram[i];
        written  <= 1'b0;
        pull_low <= 1'b1;
        busy_cnt <= STORE_T;
        n_stores <= n_stores + 1;
    endtask : store_now
    // Device sequencing
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            busy_cnt  <= RECALL_T;
            cs_q      <= 1'b1;
            wr_seen   <= 1'b0;
            wr_hold   <= 1'b0;
            written   <= 1'b0;
            hw_seen   <= 1'b0;
            pull_low  <= 1'b0;
            step      <= 3'd0;
            entry_cnt <= 0;
        end
        else
        begin
            cs_q   <= chip_sel_n;
            last_q <= mem_data_i;
            wr_seen <= !chip_sel_n && (wr_seen || !wr_strobe_n);
            // A write standing as busy ends waits for a fresh strobe edge
            if (busy_cnt == 1 && !chip_sel_n && !wr_strobe_n) wr_hold <= 1'b1;
            else if (chip_sel_n || wr_strobe_n) wr_hold <= 1'b0;
            if (busy_cnt > 0)
            begin
                busy_cnt <= busy_cnt - 1;
                if (busy_cnt == 1) pull_low <= 1'b0;
            end
            else if (!line_n && !hw_seen)
            begin
                entry_cnt <= entry_cnt + 1;
                if (entry_cnt == ENTRY_T)
                begin
                    hw_seen <= 1'b1;
                    if (written) store_now();
                end
            end
            else if (chip_sel_n && !cs_q)
            begin
                if (wr_seen)
                begin
                    if (line_n && !wr_hold) sram[mem_addr] <= mem_data_o;
                    written <= 1'b1;
                    step    <= 3'd0;
                end
                else if (step == 3'd5 && mem_addr == nv_ctrl_pkg::SEQ_STORE)
                begin
                    store_now();
                    step <= 3'd0;
                end
                else if (step == 3'd5 && mem_addr == nv_ctrl_pkg::SEQ_RECALL)
                begin
                    for (int i = 0; i < 8192; i++) sram[i] <= nv[i];
                    written   <= 1'b0;
                    busy_cnt  <= RECALL_T;
                    n_recalls <= n_recalls + 1;
                    step      <= 3'd0;
                end
                else step <= (step < 3'd5 && mem_addr == step_addr) ? step + 3'd1 : 3'd0;
            end
            if (line_n) hw_seen <= 1'b0;
            if (line_n) entry_cnt <= 0;
        end
    end
endmodule : nv_device_model

// >>> verification/nv_ctrl_checker.sv
`timescale 1ns/1ps
module nv_ctrl_checker #(
    parameter int STORE_WAIT  = 20,
    parameter int RECALL_WAIT = 20,
    parameter int ENTRY_WAIT  = 20
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_b,
    // Watched ports
    input  wire logic req_ready,
    input  wire logic hw_store_req,
    input  wire logic rsp_valid,
    input  wire logic chip_sel_n,
    input  wire logic wr_strobe_n,
    input  wire logic store_busy_line_n_i,
    input  wire logic store_busy_line_n_oe
);
    int boot_cnt; // Cycles since reset release, saturating
    int oe_cnt;   // Cycles the line has been pulled by us
    // Count boot time and pull time
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            boot_cnt <= 0;
            oe_cnt   <= 0;
        end
        else
        begin
            boot_cnt <= (boot_cnt > RECALL_WAIT) ? boot_cnt : boot_cnt + 1;
            oe_cnt   <= store_busy_line_n_oe ? oe_cnt + 1 : 0;
        end
    end
    default clocking dflt @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    a_boot_ready_wait: assert property (req_ready |-> boot_cnt >= RECALL_WAIT)
        else $error("ready raised during power-up recall");
    a_ready_line_low: assert property (!store_busy_line_n_i |-> !req_ready)
        else $error("ready while store line low");
    a_ready_hw_req: assert property (hw_store_req |-> !req_ready)
        else $error("ready while hardware store asked");
    a_write_line_high: assert property ($fell(wr_strobe_n) |-> store_busy_line_n_i && !store_busy_line_n_oe)
        else $error("write started with store line low");
    a_access_line_high: assert property ($fell(chip_sel_n) |-> store_busy_line_n_i)
        else $error("access started with store line low");
    a_pull_hold_min: assert property ($rose(store_busy_line_n_oe) |=> store_busy_line_n_oe[*8])
        else $error("store line pull too short");
    a_pull_full_span: assert property ($fell(store_busy_line_n_oe) |-> oe_cnt >= ENTRY_WAIT + STORE_WAIT)
        else $error("store line released before entry and store time");
    a_strobe_low_span: assert property ($fell(chip_sel_n) |-> !chip_sel_n[*8])
        else $error("select pulse too short");
    a_answer_one_cycle: assert property (rsp_valid |=> !rsp_valid)
        else $error("answer longer than one cycle");
    c_hw_store: cover property ($rose(store_busy_line_n_oe));
    c_answer: cover property (rsp_valid);
    c_device_pull: cover property (!store_busy_line_n_i && !store_busy_line_n_oe);
endmodule : nv_ctrl_checker
bind nv_store_recall_control nv_ctrl_checker #(.STORE_WAIT(STORE_WAIT), .RECALL_WAIT(RECALL_WAIT),
    .ENTRY_WAIT(ENTRY_WAIT)) u_checker (.clk_sys(clk_sys), .rst_b(rst_b), .req_ready(req_ready),
    .hw_store_req(hw_store_req), .rsp_valid(rsp_valid), .chip_sel_n(chip_sel_n),
    .wr_strobe_n(wr_strobe_n), .store_busy_line_n_i(store_busy_line_n_i),
    .store_busy_line_n_oe(store_busy_line_n_oe));

// >>> verification/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic        req_valid = 1'b0;
    logic [1:0]  req_op = 2'h0;
    logic [12:0] req_addr = 13'h0000;
    logic [7:0]  req_wdata = 8'h00;
    logic        hw_store_req = 1'b0;
    logic        req_ready, rsp_valid, mem_data_oe, chip_sel_n, wr_strobe_n, out_drive_n;
    logic [7:0]  rsp_rdata, mem_data_i, mem_data_o;
    logic [12:0] mem_addr, a;
    logic        line_o, line_oe, dev_pull, line_n;
    logic [8:0]  exp_q [$]; // Expected answers; bit 8 marks read data to compare
    logic [8:0]  e;
    logic [7:0]  d [0:3];
    logic [12:0] ra [0:3];
    int          n_errors = 0;
    int          n_checks = 0;
    int          seed = 57315;
    always #2.5 clk_sys = ~clk_sys;
    // Pulled-up line: low while either side pulls
    assign line_n = !((line_oe && !line_o) || dev_pull);
    nv_store_recall_control #(.STORE_WAIT(20), .RECALL_WAIT(20), .ENTRY_WAIT(20)) dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .req_valid(req_valid), .req_ready(req_ready),
        .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata), .hw_store_req(hw_store_req),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_addr(mem_addr), .mem_data_i(mem_data_i),
        .mem_data_o(mem_data_o), .mem_data_oe(mem_data_oe), .chip_sel_n(chip_sel_n),
        .wr_strobe_n(wr_strobe_n), .out_drive_n(out_drive_n), .store_busy_line_n_i(line_n),
        .store_busy_line_n_o(line_o), .store_busy_line_n_oe(line_oe));
    nv_device_model dev (.clk_sys(clk_sys), .rst_b(rst_b), .mem_addr(mem_addr),
        .mem_data_o(mem_data_o), .mem_data_i(mem_data_i), .chip_sel_n(chip_sel_n),
        .wr_strobe_n(wr_strobe_n), .out_drive_n(out_drive_n), .line_n(line_n),
        .pull_low(dev_pull));
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    // Wait at falling edges for the controller to take requests again
    task automatic wait_ready();
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 3000)
        begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 3000) check("ready wait", 16'h0001, 16'h0000);
    endtask : wait_ready
    // Offer one request; reads and writes note their answer
    task automatic do_req(input logic [1:0] op, input logic [12:0] ad, input logic [8:0] ex);
        @(negedge clk_sys);
        wait_ready();
        req_valid = 1'b1;
        req_op    = op;
        req_addr  = ad;
        req_wdata = ex[7:0];
        if (op == nv_ctrl_pkg::OP_READ || op == nv_ctrl_pkg::OP_WRITE) exp_q.push_back(ex);
        @(negedge clk_sys);
        req_valid = 1'b0;
        if (op[1]) wait_ready();
    endtask : do_req
    // Ask a store through the line and wait until it is released
    task automatic hw_store();
        @(negedge clk_sys);
        wait_ready();
        hw_store_req = 1'b1;
        while (line_oe !== 1'b1) @(negedge clk_sys);
        hw_store_req = 1'b0;
        @(negedge clk_sys);
        wait_ready();
    endtask : hw_store
    // Answer watcher
    always @(negedge clk_sys)
    begin
        if (rst_b && rsp_valid === 1'b1)
        begin
            if (exp_q.size() == 0) check("spare answer", 16'h0001, 16'h0000);
            else
            begin
                e = exp_q.pop_front();
                if (e[8]) check("read data", {8'h00, rsp_rdata}, {8'h00, e[7:0]});
            end
        end
    end
    // Main sequence
    initial
    begin
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_b = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            a     = $random(seed);
            ra[i] = {a[12:2], 2'(i)};
            d[i]  = $random(seed);
            do_req(nv_ctrl_pkg::OP_WRITE, ra[i], {1'b0, d[i]});
        end
        for (int i = 0; i < 4; i++) do_req(nv_ctrl_pkg::OP_READ, ra[i], {1'b1, d[i]});
        a = ra[0];
        do_req(nv_ctrl_pkg::OP_WRITE, a, 9'h05A);
        do_req(nv_ctrl_pkg::OP_SW_STORE, 13'h0000, 9'h000);
        check("store count", 16'(dev.n_stores), 16'h0001);
        do_req(nv_ctrl_pkg::OP_WRITE, a, 9'h0C3);
        do_req(nv_ctrl_pkg::OP_READ, a, 9'h1C3);
        do_req(nv_ctrl_pkg::OP_SW_RECALL, 13'h0000, 9'h000);
        check("recall count", 16'(dev.n_recalls), 16'h0001);
        do_req(nv_ctrl_pkg::OP_READ, a, 9'h15A);
        do_req(nv_ctrl_pkg::OP_SW_STORE, 13'h0000, 9'h000);
        check("store count", 16'(dev.n_stores), 16'h0002);
        hw_store();
        check("store count", 16'(dev.n_stores), 16'h0002);
        do_req(nv_ctrl_pkg::OP_WRITE, a, 9'h03C);
        hw_store();
        check("store count", 16'(dev.n_stores), 16'h0003);
        do_req(nv_ctrl_pkg::OP_WRITE, a, 9'h0E1);
        do_req(nv_ctrl_pkg::OP_SW_RECALL, 13'h0000, 9'h000);
        do_req(nv_ctrl_pkg::OP_READ, a, 9'h13C);
        repeat (100) @(negedge clk_sys);
        check("pending answers", 16'(exp_q.size()), 16'h0000);
        print_verdict();
    end
    // Watchdog
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        print_verdict();
    end
endmodule : testbench
